//--- pkg/rac_pkg.sv
// shared constants for the reset and action-request control pair
// assumes both ends run on one 100 MHz system clock and share this package
package rac_pkg;

    // ************************************************************
    // clock and timing
    // ************************************************************
    localparam int SCLK_PERIOD_NS = 10;
    // final reset phase after the reset pin falls, in system clock cycles
    localparam int FINAL_PHASE_CYC = 12;
    // host guard between reset fall and the first action request
    localparam int REQ_GUARD_CYC = 12;
    // action request strobe width limits
    localparam int REQ_PULSE_MIN_CYC = 2;
    localparam int REQ_PULSE_MAX_CYC = 5;
    localparam int REQ_PULSE_DEF_CYC = 3;
    // least reset pulse width
    localparam int RESET_MIN_CYC = 2;
    // idle cycles between two polls of a held descriptor
    localparam int POLL_GAP_DEF_CYC = 4;

    // ************************************************************
    // memory bus and descriptor layout
    // ************************************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CNT_W = 8;
    localparam logic [ADDR_W-1:0] INIT_BASE_ADDR = 8'h00;
    localparam int INIT_WORDS_DEF = 2;
    // init word 0 carries the first transmit descriptor address
    localparam int INIT_FIRST_LSB = 0;
    localparam int DESC_HOLD_BIT = 30;
    localparam int DESC_NEXT_LSB = 8;
    localparam int DESC_PAYLOAD_LSB = 0;
    localparam int PAYLOAD_W = 8;

endpackage

//--- pkg/rac_if.sv
// link between the host end and the device end
// assumes both ends share clk; the testbench instantiates it and joins them
`timescale 1ns/1ps
interface rac_if
    import rac_pkg::*;
    ();
    logic resetPin;
    logic actionRequestStrobe;
    logic memRd;
    logic [ADDR_W-1:0] memAddr;
    logic memOe;
    logic memAck;
    logic [DATA_W-1:0] memData;
    // resolved bus: a released bus reads as idle
    logic busRd;
    logic [ADDR_W-1:0] busAddr;

    assign busRd = memOe ? memRd : 1'b0;
    assign busAddr = memOe ? memAddr : '0;

    modport dev (
        input resetPin,
        input actionRequestStrobe,
        input memAck,
        input memData,
        output memRd,
        output memAddr,
        output memOe
    );

    modport hst (
        output resetPin,
        output actionRequestStrobe,
        output memAck,
        output memData,
        input busRd,
        input busAddr
    );
endinterface

//--- core/rac_device.sv
// device end: reset sequencing, action request intake, init fetch and
// descriptor chain walk with hold-bit polling
// assumes the host end answers each memory read one cycle after it sees it
`timescale 1ns/1ps
module rac_device
    import rac_pkg::*;
    #(
    parameter int INIT_WORDS = INIT_WORDS_DEF,
    parameter int POLL_GAP_CYC = POLL_GAP_DEF_CYC
    ) (
    input wire logic clk,                  // system clock
    input wire logic rstn,                 // async reset, active low
    rac_if.dev link,                       // link to the host end
    output logic initDone,                 // init data fetched
    output logic txValid,                  // one-cycle frame pulse
    output logic [PAYLOAD_W-1:0] txByte,   // payload of the frame sent
    output logic polling                   // waiting on a held descriptor
    );

    // ************************************************************
    // parameter checks
    // ************************************************************
    if (INIT_WORDS < 1 || INIT_WORDS > 255) begin : gInitChk
        $error("INIT_WORDS out of range");
    end
    if (POLL_GAP_CYC < 1 || POLL_GAP_CYC > 255) begin : gPollChk
        $error("POLL_GAP_CYC out of range");
    end

    localparam logic [CNT_W-1:0] FINAL_LAST = CNT_W'(FINAL_PHASE_CYC - 1);
    localparam logic [CNT_W-1:0] POLL_LAST = CNT_W'(POLL_GAP_CYC - 1);
    localparam logic [CNT_W-1:0] INIT_LAST = CNT_W'(INIT_WORDS - 1);

    typedef enum logic [2:0] {
        ST_RESET,
        ST_FINAL,
        ST_IDLE,
        ST_INIT,
        ST_DESC,
        ST_POLL
    } rac_dev_state_t;

    // ************************************************************
    // state
    // ************************************************************
    rac_dev_state_t state, next_state;
    logic [CNT_W-1:0] cnt, next_cnt;
    logic [CNT_W-1:0] wordIdx, next_wordIdx;
    logic [ADDR_W-1:0] firstDesc, next_firstDesc;
    logic sent, next_sent;
    logic reqPrev, next_reqPrev;
    logic memRd, next_memRd;
    logic [ADDR_W-1:0] memAddr, next_memAddr;
    logic memOe, next_memOe;
    logic next_initDone;
    logic next_txValid;
    logic [PAYLOAD_W-1:0] next_txByte;
    logic next_polling;
    logic reqRise;
    logic [ADDR_W-1:0] rdNext;
    logic [ADDR_W-1:0] rdFirst;

    assign reqRise = link.actionRequestStrobe && !reqPrev;
    assign rdNext = link.memData[DESC_NEXT_LSB +: ADDR_W];
    assign rdFirst = link.memData[INIT_FIRST_LSB +: ADDR_W];

    assign link.memRd = memRd;
    assign link.memAddr = memAddr;
    assign link.memOe = memOe;

    // ************************************************************
    // next-state logic
    // ************************************************************
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_wordIdx = wordIdx;
        next_firstDesc = firstDesc;
        next_sent = sent;
        next_reqPrev = link.actionRequestStrobe;
        next_memRd = memRd;
        next_memAddr = memAddr;
        next_memOe = memOe;
        next_initDone = initDone;
        next_txValid = 1'b0;
        next_txByte = txByte;
        next_polling = polling;
        if (link.resetPin) begin
            next_state = ST_RESET;
            next_cnt = '0;
            next_memRd = 1'b0;
            next_memOe = 1'b0;
            next_initDone = 1'b0;
            next_polling = 1'b0;
            next_sent = 1'b0;
        end else begin
            unique case (state)
                ST_RESET: begin
                    next_state = ST_FINAL;
                    next_cnt = '0;
                end
                ST_FINAL: begin
                    next_cnt = cnt + CNT_W'(1);
                    if (cnt == FINAL_LAST) begin
                        // bus enabled only after the sequence
                        next_state = ST_IDLE;
                        next_memOe = 1'b1;
                        next_cnt = '0;
                    end
                end
                ST_IDLE: begin
                    if (reqRise) begin
                        next_state = ST_INIT;
                        next_memRd = 1'b1;
                        next_memAddr = INIT_BASE_ADDR;
                        next_wordIdx = '0;
                    end
                end
                ST_INIT: begin
                    if (link.memAck) begin
                        if (wordIdx == '0) begin
                            next_firstDesc = rdFirst;
                        end
                        if (wordIdx == INIT_LAST) begin
                            // then walk to the first frame
                            next_state = ST_DESC;
                            next_initDone = 1'b1;
                            next_sent = 1'b0;
                            next_memAddr = (wordIdx == '0) ? rdFirst : firstDesc;
                        end else begin
                            next_wordIdx = wordIdx + CNT_W'(1);
                            next_memAddr = memAddr + ADDR_W'(1);
                        end
                    end
                end
                ST_DESC: begin
                    if (link.memAck) begin
                        if (!sent) begin
                            next_txValid = 1'b1;
                            next_txByte = link.memData[DESC_PAYLOAD_LSB +: PAYLOAD_W];
                            next_sent = 1'b1;
                        end
                        if (link.memData[DESC_HOLD_BIT]) begin
                            next_state = ST_POLL;
                            next_memRd = 1'b0;
                            next_cnt = '0;
                            next_polling = 1'b1;
                        end else begin
                            next_memAddr = rdNext;
                            next_sent = 1'b0;
                            next_polling = 1'b0;
                        end
                    end
                end
                ST_POLL: begin
                    next_cnt = cnt + CNT_W'(1);
                    if (cnt == POLL_LAST) begin
                        next_state = ST_DESC;
                        next_memRd = 1'b1;
                    end
                end
            endcase
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state <= ST_RESET;
            cnt <= '0;
            wordIdx <= '0;
            firstDesc <= '0;
            sent <= 1'b0;
            reqPrev <= 1'b0;
            memRd <= 1'b0;
            memAddr <= '0;
            memOe <= 1'b0;
            initDone <= 1'b0;
            txValid <= 1'b0;
            txByte <= '0;
            polling <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            wordIdx <= next_wordIdx;
            firstDesc <= next_firstDesc;
            sent <= next_sent;
            reqPrev <= next_reqPrev;
            memRd <= next_memRd;
            memAddr <= next_memAddr;
            memOe <= next_memOe;
            initDone <= next_initDone;
            txValid <= next_txValid;
            txByte <= next_txByte;
            polling <= next_polling;
        end
    end

endmodule

//--- core/rac_host.sv
// host end: drives the reset pin and the action request strobe with legal
// timing, and serves the device's memory reads from a local array
// assumes the device end shares clk
`timescale 1ns/1ps
module rac_host
    import rac_pkg::*;
    #(
    parameter int RESET_HOLD_CYC = RESET_MIN_CYC,
    parameter int REQ_PULSE_CYC = REQ_PULSE_DEF_CYC,
    parameter int MEM_DEPTH = 256
    ) (
    input wire logic clk,                  // system clock
    input wire logic rstn,                 // async reset, active low
    rac_if.hst link,                       // link to the device end
    input wire logic startReset,           // pulse: reset the device
    input wire logic startAction,          // pulse: send an action request
    input wire logic wrEn,                 // memory write strobe
    input wire logic [ADDR_W-1:0] wrAddr,  // memory write address
    input wire logic [DATA_W-1:0] wrData,  // memory write data
    output logic hostReady                 // an action request is accepted now
    );

    // ************************************************************
    // parameter checks
    // ************************************************************
    if (REQ_PULSE_CYC < REQ_PULSE_MIN_CYC || REQ_PULSE_CYC > REQ_PULSE_MAX_CYC) begin : gReqChk
        $error("REQ_PULSE_CYC outside legal strobe width");
    end
    if (RESET_HOLD_CYC < RESET_MIN_CYC || RESET_HOLD_CYC > 255) begin : gRstChk
        $error("RESET_HOLD_CYC too short");
    end
    if (MEM_DEPTH != (1 << ADDR_W)) begin : gMemChk
        $error("MEM_DEPTH must cover the address space");
    end

    localparam logic [CNT_W-1:0] RST_LAST = CNT_W'(RESET_HOLD_CYC - 1);
    localparam logic [CNT_W-1:0] GUARD_LAST = CNT_W'(REQ_GUARD_CYC - 1);
    localparam logic [CNT_W-1:0] PULSE_LAST = CNT_W'(REQ_PULSE_CYC - 1);

    typedef enum logic [1:0] {
        H_RESET,
        H_GUARD,
        H_IDLE,
        H_PULSE
    } rac_host_state_t;

    rac_host_state_t state, next_state;
    logic [CNT_W-1:0] cnt, next_cnt;
    logic resetPin, next_resetPin;
    logic reqStrobe, next_reqStrobe;
    logic next_hostReady;
    logic memAck, next_memAck;
    logic [DATA_W-1:0] memData, next_memData;
    logic [DATA_W-1:0] mem [MEM_DEPTH];

    assign link.resetPin = resetPin;
    assign link.actionRequestStrobe = reqStrobe;
    assign link.memAck = memAck;
    assign link.memData = memData;

    // ************************************************************
    // reset and strobe sequencing
    // ************************************************************
    always_comb begin
        next_state = state;
        next_cnt = cnt + CNT_W'(1);
        next_resetPin = resetPin;
        next_reqStrobe = 1'b0;
        next_hostReady = 1'b0;
        unique case (state)
            H_RESET: begin
                next_resetPin = 1'b1;
                if (cnt == RST_LAST) begin
                    next_state = H_GUARD;
                    next_resetPin = 1'b0;
                    next_cnt = '0;
                end
            end
            H_GUARD: begin
                if (cnt == GUARD_LAST) begin
                    next_state = H_IDLE;
                    next_hostReady = 1'b1;
                end
            end
            H_IDLE: begin
                next_hostReady = 1'b1;
                next_cnt = '0;
                if (startReset) begin
                    next_state = H_RESET;
                    next_resetPin = 1'b1;
                    next_hostReady = 1'b0;
                end else if (startAction) begin
                    next_state = H_PULSE;
                    next_reqStrobe = 1'b1;
                    next_hostReady = 1'b0;
                end
            end
            H_PULSE: begin
                next_reqStrobe = 1'b1;
                if (cnt == PULSE_LAST) begin
                    next_state = H_IDLE;
                    next_reqStrobe = 1'b0;
                    next_hostReady = 1'b1;
                end
            end
        endcase
    end

    // ************************************************************
    // memory answer: one cycle per read, then one idle cycle
    // ************************************************************
    always_comb begin
        next_memAck = link.busRd && !memAck;
        next_memData = mem[link.busAddr];
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state <= H_RESET;
            cnt <= '0;
            resetPin <= 1'b1;
            reqStrobe <= 1'b0;
            hostReady <= 1'b0;
            memAck <= 1'b0;
            memData <= '0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            resetPin <= next_resetPin;
            reqStrobe <= next_reqStrobe;
            hostReady <= next_hostReady;
            memAck <= next_memAck;
            memData <= next_memData;
        end
    end

    // software links a descriptor, then clears the old hold
    always_ff @(posedge clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
    end

endmodule

//--- testbench/rac_asserts.sv
// checker on the link signals between host end and device end
// assumes one clock; the bench instantiates it beside the link
`timescale 1ns/1ps
module rac_asserts
    import rac_pkg::*;
    #(
    parameter int INIT_WORDS = INIT_WORDS_DEF
    ) (
    input wire logic clk, // system clock
    input wire logic rstn, // async reset, active low
    input wire logic resetPin, // device reset pin
    input wire logic actionRequestStrobe, // request strobe
    input wire logic memRd, // read request
    input wire logic [ADDR_W-1:0] memAddr, // read address
    input wire logic memOe, // bus drive enable
    input wire logic memAck, // read answer
    input wire logic [DATA_W-1:0] memData // read data
    );
    localparam int POLL_MAX = 8;
    logic [CNT_W-1:0] ackCnt;
    logic [CNT_W-1:0] next_ackCnt;
    logic [ADDR_W-1:0] heldAddr;
    logic [ADDR_W-1:0] next_heldAddr;
    logic [ADDR_W-1:0] firstDesc;
    logic [ADDR_W-1:0] next_firstDesc;
    logic walking;
    logic [ADDR_W-1:0] nextField;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // ******
    // answered init reads since the last pin reset, held at INIT_WORDS
    // ******
    assign walking = (ackCnt >= CNT_W'(INIT_WORDS));
    assign nextField = memData[DESC_NEXT_LSB +: ADDR_W];
    always_comb begin
        next_ackCnt = ackCnt;
        next_heldAddr = heldAddr;
        next_firstDesc = firstDesc;
        if (resetPin) begin
            next_ackCnt = '0;
        end else if (memAck && !walking) begin
            next_ackCnt = ackCnt + 8'h01;
        end
        if (memAck) begin
            next_heldAddr = memAddr;
        end
        if (memAck && ackCnt == '0 && !resetPin) begin
            next_firstDesc = memData[INIT_FIRST_LSB +: ADDR_W];
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ackCnt <= '0;
            heldAddr <= '0;
            firstDesc <= '0;
        end else begin
            ackCnt <= next_ackCnt;
            heldAddr <= next_heldAddr;
            firstDesc <= next_firstDesc;
        end
    end

    // ******
    // assertions
    // ******
    bus_idle_reset_a:
        assert property (resetPin |=> !memOe && !memRd) else $error("bus active in reset");
    final_phase_a:
        assert property ($fell(resetPin) |-> !memOe [*8] ##1 !memOe [*5] ##[1:2] memOe)
        else $error("final reset phase length wrong");
    req_guard_a:
        assert property ($fell(resetPin) |-> !actionRequestStrobe [*8] ##1 !actionRequestStrobe [*4])
        else $error("request inside guard time");
    req_width_a:
        assert property ($rose(actionRequestStrobe) |=> actionRequestStrobe ##[1:4] !actionRequestStrobe)
        else $error("request strobe width wrong");
    reset_width_a:
        assert property ($rose(resetPin) |=> resetPin) else $error("reset pulse too short");
    no_read_idle_a:
        assert property (!memOe |-> !memRd) else $error("read while bus released");
    init_fetch_a:
        assert property (disable iff (!rstn || resetPin)
            $rose(actionRequestStrobe) && memOe && ackCnt == '0 && !memRd |=>
            memRd && memAddr == INIT_BASE_ADDR) else $error("no init fetch after request");
    first_frame_a:
        assert property (disable iff (!rstn || resetPin)
            memAck && ackCnt == CNT_W'(INIT_WORDS - 1) |=> memRd && memAddr == firstDesc)
        else $error("first descriptor not fetched");
    poll_gap_a:
        assert property (disable iff (!rstn || resetPin)
            memAck && walking && memData[DESC_HOLD_BIT] |=>
            !memRd ##[1:POLL_MAX] (memRd && memAddr == heldAddr)) else $error("held descriptor not polled");
    chain_next_a:
        assert property (disable iff (!rstn || resetPin)
            memAck && walking && !memData[DESC_HOLD_BIT] |=> memRd && memAddr == $past(nextField))
        else $error("chain not followed");

    cover property ($rose(actionRequestStrobe) && memOe);
    cover property (memAck && walking && memData[DESC_HOLD_BIT]);
    cover property ($fell(resetPin));
endmodule

//--- testbench/reset_and_action_request_control_bench.sv
// bench joining host end and device end, with scoreboard of sent payloads
// assumes the shared package and the link interface are compiled first
`timescale 1ns/1ps
module reset_and_action_request_control_bench
    import rac_pkg::*;
    ;
    logic clk;
    logic rstn;
    logic startReset;
    logic startAction;
    logic wrEn;
    logic [ADDR_W-1:0] wrAddr;
    logic [DATA_W-1:0] wrData;
    logic initDone;
    logic txValid;
    logic [PAYLOAD_W-1:0] txByte;
    logic polling;
    logic hostReady;
    logic [ADDR_W-1:0] lastA;
    logic [PAYLOAD_W-1:0] expQ[$];
    int errorCnt = 0;
    int numChecks = 0;

    rac_if rac_if_inst ();
    rac_device #(.INIT_WORDS(INIT_WORDS_DEF)) rac_device_inst (.clk(clk), .rstn(rstn), .link(rac_if_inst),
        .initDone(initDone), .txValid(txValid), .txByte(txByte), .polling(polling));
    rac_host rac_host_inst (.clk(clk), .rstn(rstn), .link(rac_if_inst), .startReset(startReset),
        .startAction(startAction), .wrEn(wrEn), .wrAddr(wrAddr), .wrData(wrData), .hostReady(hostReady));
    rac_asserts #(.INIT_WORDS(INIT_WORDS_DEF)) rac_asserts_inst (.clk(clk), .rstn(rstn),
        .resetPin(rac_if_inst.resetPin), .actionRequestStrobe(rac_if_inst.actionRequestStrobe),
        .memRd(rac_if_inst.memRd), .memAddr(rac_if_inst.memAddr), .memOe(rac_if_inst.memOe),
        .memAck(rac_if_inst.memAck), .memData(rac_if_inst.memData));

    always #(SCLK_PERIOD_NS / 2) clk = ~clk;

    // ******
    // tasks
    // ******
    task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        numChecks++;
        if (seen !== exp) begin
            errorCnt++;
            $display("BAD %0t: saw %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic giveVerdict();
        if (errorCnt == 0 && numChecks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // leaves wrEn high so back-to-back writes never toggle it within one step
    task automatic memWrite(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        wrEn = 1'b1;
        wrAddr = a;
        wrData = d;
        tick(1);
    endtask

    function automatic logic [DATA_W-1:0] desc(input logic hold, input logic [ADDR_W-1:0] nxt,
        input logic [PAYLOAD_W-1:0] pl);
        desc = '0;
        desc[DESC_HOLD_BIT] = hold;
        desc[DESC_NEXT_LSB +: ADDR_W] = nxt;
        desc[DESC_PAYLOAD_LSB +: PAYLOAD_W] = pl;
    endfunction

    task automatic settle();
        repeat (400) if (expQ.size() != 0 || polling !== 1'b1) tick(1);
        check(DATA_W'(expQ.size()), 32'h0);
        check(DATA_W'(polling), 32'h1);
    endtask

    task automatic startChain(input logic [ADDR_W-1:0] a0);
        logic [PAYLOAD_W-1:0] p0;
        logic [PAYLOAD_W-1:0] p1;
        p0 = PAYLOAD_W'($urandom);
        p1 = PAYLOAD_W'($urandom);
        memWrite(INIT_BASE_ADDR, DATA_W'(a0));
        memWrite(INIT_BASE_ADDR + 8'h01, DATA_W'($urandom));
        memWrite(a0, desc(1'b0, a0 + 8'h01, p0));
        memWrite(a0 + 8'h01, desc(1'b1, 8'h00, p1));
        wrEn = 1'b0;
        lastA = a0 + 8'h01;
        expQ.push_back(p0);
        expQ.push_back(p1);
        repeat (100) if (hostReady !== 1'b1) tick(1);
        check(DATA_W'(hostReady), 32'h1);
        startAction = 1'b1;
        tick(1);
        startAction = 1'b0;
        settle();
        check(DATA_W'(initDone), 32'h1);
    endtask

    // link then clear
    // new descriptors first, old hold cleared last, so no half-built chain is read
    task automatic addFrames(input int m);
        logic [PAYLOAD_W-1:0] p;
        for (int i = 1; i <= m; i++) begin
            p = PAYLOAD_W'($urandom);
            expQ.push_back(p);
            memWrite(lastA + ADDR_W'(i), desc(i == m, lastA + ADDR_W'(i + 1), p));
        end
        memWrite(lastA, desc(1'b0, lastA + 8'h01, 8'h00));
        wrEn = 1'b0;
        lastA = lastA + ADDR_W'(m);
        settle();
    endtask

    always @(posedge clk) begin
        if (txValid === 1'b1) begin
            if (expQ.size() == 0) begin
                check(32'h1, 32'h0);
            end else begin
                check(DATA_W'(txByte), DATA_W'(expQ.pop_front()));
            end
        end
    end

    // ******
    // scenarios
    // ******
    initial begin
        clk = 1'b0;
        rstn = 1'b0;
        startReset = 1'b0;
        startAction = 1'b0;
        wrEn = 1'b0;
        wrAddr = '0;
        wrData = '0;
        lastA = '0;
        void'($urandom(32'h22A0A6B6));
        tick(15);
        check(DATA_W'(rac_if_inst.memOe), 32'h0);
        check(DATA_W'(rac_if_inst.resetPin), 32'h1);
        tick(1);
        rstn = 1'b1;
        startChain(8'h10 + ADDR_W'($urandom % 32));
        for (int k = 0; k < 6; k++) begin
            addFrames(1 + k % 3);
        end
        startReset = 1'b1;
        tick(1);
        startReset = 1'b0;
        tick(2);
        check(DATA_W'(rac_if_inst.memOe), 32'h0);
        check(DATA_W'(polling), 32'h0);
        check(DATA_W'(initDone), 32'h0);
        startChain(8'h80 + ADDR_W'($urandom % 32));
        addFrames(2);
        giveVerdict();
    end

    initial begin
        repeat (20000) @(posedge clk);
        errorCnt++;
        giveVerdict();
    end
endmodule
